//--- core/operand_address_flags.sv
// Operand address generation and arithmetic condition flags with an APB register port.
// Function
// RQ1: Flag bits written by a flag-updating instruction take the operation result instead.
// RQ2: Clearing the flag register sets zero and leaves other flags unchanged.
// RQ3: Software should alter flags only with bit, swap or move instructions.
// RQ4: Upper three flag bits read zero; five flag bits are read-write.
// RQ5: Negative flag takes result bit seven.
// RQ6: Signed overflow flag set when sign bit changes wrongly.
// RQ7: Zero flag set when the result is zero.
// RQ8: Nibble carry records carry out of bit three for add and subtract.
// RQ9: Carry records carry out of bit seven for add and subtract.
// RQ10: Subtract adds two's complement; carries act as inverted borrows.
// RQ11: Rotate through carry loads carry with shifted bit, nibble carry bit four or three.
// RQ12: Absolute call and jump carry a twenty-bit target literal.
// RQ13: Byte and bit instructions use the low opcode byte as direct address.
// RQ14: Access select one joins bank pointer and file address into twelve bits.
// RQ15: Access select zero maps file address into the access bank.
// RQ16: Full-address instructions ignore the bank pointer.
// RQ17: Destination select one writes back to file, zero to the accumulator.
// RQ18: Three pointers of high and low byte, twelve bits used.
// RQ19: Virtual pointer operands access memory at their pointer address.
// RQ20: Indirect accesses use the full pointer, ignoring bank and access select.
// RQ21: Indexed literal offset mode exists only with extended operations enabled.
// RQ22: Extended access-bank addresses up to 5Fh offset the third pointer.
// RQ23: Pointer increment and decrement carry across bytes and leave flags alone.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps

module operand_address_flags
	import opaddr_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire opaddr_pkg::instr_s  instr,
	output opaddr_pkg::access_s      access
);
	import opaddr_pkg::*;

	typedef struct packed
	{
		logic [4:0]  flags;
		logic [3:0]  bank;
		logic [11:0] ptr0;
		logic [11:0] ptr1;
		logic [11:0] ptr2;
		logic        ext_en;
		logic [11:0] last_addr;
		access_s     acc;
		logic [31:0] rdata;
		logic        slverr;
	} state_s;

	state_s st_q;
	state_s st_d;

	logic [11:0] ptr0_next;
	logic [11:0] ptr0_addr;
	logic [11:0] ptr1_next;
	logic [11:0] ptr1_addr;
	logic [11:0] ptr2_next;
	logic [11:0] ptr2_addr;
	logic [11:0] ptr_new;
	logic [11:0] ptr_use;
	logic [11:0] target;
	logic [8:0]  sum;
	logic [4:0]  low_sum;
	logic [7:0]  addend;
	logic        sub_op;
	logic [7:0]  res;
	logic [4:0]  flags_alu;
	logic        flags_hit;
	logic        apb_wr;
	logic        apb_rd;
	logic        decode_ok;

	pointer_step #(
		.WIDTH(12)
	) pointer_step_0_i (
		.ptr_cur  (st_q.ptr0),
		.ptr_op   (instr.ptr_op),
		.ptr_next (ptr0_next),
		.ptr_addr (ptr0_addr)
	);

	pointer_step #(
		.WIDTH(12)
	) pointer_step_1_i (
		.ptr_cur  (st_q.ptr1),
		.ptr_op   (instr.ptr_op),
		.ptr_next (ptr1_next),
		.ptr_addr (ptr1_addr)
	);

	pointer_step #(
		.WIDTH(12)
	) pointer_step_2_i (
		.ptr_cur  (st_q.ptr2),
		.ptr_op   (instr.ptr_op),
		.ptr_next (ptr2_next),
		.ptr_addr (ptr2_addr)
	);

	always_comb
	begin
		case (instr.ptr_sel)
			2'h1:
			begin
				ptr_new = ptr1_next;
				ptr_use = ptr1_addr; // RQ19
			end
			2'h2:
			begin
				ptr_new = ptr2_next;
				ptr_use = ptr2_addr; // RQ19
			end
			default:
			begin
				ptr_new = ptr0_next;
				ptr_use = ptr0_addr; // RQ19
			end
		endcase
	end

	always_comb
	begin
		target = 12'h000;
		case (instr.src)
			SRC_DIRECT:
			begin
				if (instr.access_sel)
				begin
					target = {st_q.bank, instr.file_addr}; // RQ13 RQ14
				end
				else if (st_q.ext_en && (instr.file_addr <= INDEXED_MAX_OFFSET))
				begin
					target = st_q.ptr2 + {4'h0, instr.file_addr}; // RQ21 RQ22
				end
				else if ({4'h0, instr.file_addr} >= ACCESS_SPLIT_ADDR)
				begin
					target = {ACCESS_HIGH_BANK, instr.file_addr}; // RQ15
				end
				else
				begin
					target = {4'h0, instr.file_addr}; // RQ15
				end
			end
			SRC_FULL_ADDR: target = instr.full_addr; // RQ16
			SRC_INDIRECT:  target = ptr_use; // RQ18 RQ20
			default:       target = 12'h000;
		endcase
	end

	assign sub_op = (instr.alu_op == ALU_SUB);
	// Subtraction adds the inverted operand with carry in set.
	assign addend = sub_op ? ~instr.opb : instr.opb; // RQ10

	carry_adder #(
		.WIDTH(8)
	) byte_adder_i (
		.add_a    (instr.opa),
		.add_b    (addend),
		.carry_in (sub_op),
		.sum_out  (sum)
	);

	carry_adder #(
		.WIDTH(4)
	) nibble_adder_i (
		.add_a    (instr.opa[3:0]),
		.add_b    (addend[3:0]),
		.carry_in (sub_op),
		.sum_out  (low_sum)
	);

	always_comb
	begin
		res       = instr.opb;
		flags_alu = st_q.flags;
		case (instr.alu_op)
			ALU_ADD, ALU_SUB:
			begin
				res = sum[7:0];
				flags_alu[FLAG_CARRY]  = sum[8]; // RQ9 RQ10
				flags_alu[FLAG_NIBBLE] = low_sum[4]; // RQ8 RQ10
				flags_alu[FLAG_SIGNED] = (instr.opa[7] == addend[7])
					&& (sum[7] != instr.opa[7]); // RQ6
				flags_alu[FLAG_NEGATIVE] = sum[7]; // RQ5
				flags_alu[FLAG_ZERO]     = (sum[7:0] == 8'h00); // RQ7
			end
			ALU_LOGIC:
			begin
				res = instr.opb;
				flags_alu[FLAG_NEGATIVE] = instr.opb[7]; // RQ5
				flags_alu[FLAG_ZERO]     = (instr.opb == 8'h00); // RQ7
			end
			ALU_ROT_LEFT_CARRY:
			begin
				res = {instr.opa[6:0], st_q.flags[FLAG_CARRY]};
				flags_alu[FLAG_CARRY]    = instr.opa[7]; // RQ11
				flags_alu[FLAG_NIBBLE]   = instr.opa[3]; // RQ11
				flags_alu[FLAG_NEGATIVE] = instr.opa[6];
				flags_alu[FLAG_ZERO]     = ({instr.opa[6:0], st_q.flags[FLAG_CARRY]} == 8'h00);
			end
			ALU_ROT_RIGHT_CARRY:
			begin
				res = {st_q.flags[FLAG_CARRY], instr.opa[7:1]};
				flags_alu[FLAG_CARRY]    = instr.opa[0]; // RQ11
				flags_alu[FLAG_NIBBLE]   = instr.opa[4]; // RQ11
				flags_alu[FLAG_NEGATIVE] = st_q.flags[FLAG_CARRY];
				flags_alu[FLAG_ZERO]     = ({st_q.flags[FLAG_CARRY], instr.opa[7:1]} == 8'h00);
			end
			ALU_CLEAR:
			begin
				res = 8'h00;
				flags_alu[FLAG_ZERO] = 1'b1; // RQ2
			end
			default:
			begin
				res = instr.opb;
			end
		endcase
	end

	assign flags_hit = instr.valid && instr.dest_sel && (target == REG_FLAGS_ADDR)
		&& (instr.src == SRC_DIRECT || instr.src == SRC_FULL_ADDR || instr.src == SRC_INDIRECT);
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !pwrite;

	always_comb
	begin
		case (paddr)
			REG_FLAGS_ADDR,
			REG_BANK_ADDR,
			REG_PTR0_ADDR,
			REG_PTR1_ADDR,
			REG_PTR2_ADDR,
			REG_CONFIG_ADDR,
			REG_TARGET_ADDR: decode_ok = 1'b1;
			default:         decode_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		st_d = st_q;
		st_d.acc.flag_write = 1'b0;
		st_d.acc.mem_valid  = 1'b0;
		if (apb_wr && decode_ok)
		begin
			case (paddr)
				REG_FLAGS_ADDR:  st_d.flags = pwdata[4:0]; // RQ4
				REG_BANK_ADDR:   st_d.bank = pwdata[3:0];
				REG_PTR0_ADDR:   st_d.ptr0 = pwdata[11:0]; // RQ18
				REG_PTR1_ADDR:   st_d.ptr1 = pwdata[11:0]; // RQ18
				REG_PTR2_ADDR:   st_d.ptr2 = pwdata[11:0]; // RQ18
				REG_CONFIG_ADDR: st_d.ext_en = pwdata[0]; // RQ21
				default:         st_d.ext_en = st_q.ext_en;
			endcase
		end
		if (instr.valid)
		begin
			st_d.acc.mem_valid      = (instr.src != SRC_INHERENT) && (instr.src != SRC_LITERAL);
			st_d.acc.mem_addr       = target;
			st_d.acc.to_accumulator = !instr.dest_sel; // RQ17
			st_d.acc.result         = res;
			st_d.acc.jump_target    = instr.jump_target; // RQ12
			st_d.last_addr          = target;
			if (flags_hit && instr.alu_op == ALU_NONE)
			begin
				st_d.flags = instr.write_val[4:0]; // RQ3
				st_d.acc.flag_write = 1'b1;
			end
			else if (instr.alu_op != ALU_NONE)
			begin
				st_d.flags = flags_alu; // RQ1 RQ2
				st_d.acc.flag_write = flags_hit;
			end
			if (instr.src == SRC_INDIRECT)
			begin
				case (instr.ptr_sel)
					2'h1:    st_d.ptr1 = ptr_new; // RQ23
					2'h2:    st_d.ptr2 = ptr_new; // RQ23
					default: st_d.ptr0 = ptr_new; // RQ23
				endcase
			end
		end
		st_d.slverr = psel && !penable && !decode_ok;
		if (apb_rd)
		begin
			case (paddr)
				REG_FLAGS_ADDR:  st_d.rdata = {27'h0, st_q.flags}; // RQ4
				REG_BANK_ADDR:   st_d.rdata = {28'h0, st_q.bank};
				REG_PTR0_ADDR:   st_d.rdata = {20'h0, st_q.ptr0};
				REG_PTR1_ADDR:   st_d.rdata = {20'h0, st_q.ptr1};
				REG_PTR2_ADDR:   st_d.rdata = {20'h0, st_q.ptr2};
				REG_CONFIG_ADDR: st_d.rdata = {31'h0, st_q.ext_en};
				REG_TARGET_ADDR: st_d.rdata = {20'h0, st_q.last_addr};
				default:         st_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q.flags     <= FLAGS_RESET;
			st_q.bank      <= BANK_RESET;
			st_q.ptr0      <= PTR_RESET;
			st_q.ptr1      <= PTR_RESET;
			st_q.ptr2      <= PTR_RESET;
			st_q.ext_en    <= EXT_RESET;
			st_q.last_addr <= PTR_RESET;
			st_q.acc       <= '0;
			st_q.rdata     <= 32'h0;
			st_q.slverr    <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign prdata  = st_q.rdata;
	assign pready  = psel && penable;
	assign pslverr = psel && penable && st_q.slverr;
	assign access  = st_q.acc;

endmodule

module pointer_step
	import opaddr_pkg::*;
#(
	parameter int WIDTH = 12
)
(
	input  wire logic [WIDTH-1:0]    ptr_cur,
	input  wire opaddr_pkg::ptr_op_e ptr_op,
	output logic      [WIDTH-1:0]    ptr_next,
	output logic      [WIDTH-1:0]    ptr_addr
);
	import opaddr_pkg::*;

	logic [WIDTH-1:0] inc_val;
	logic [WIDTH-1:0] dec_val;

	always_comb
	begin
		inc_val = ptr_cur + WIDTH'(1'h1); // RQ23
		dec_val = ptr_cur - WIDTH'(1'h1); // RQ23
		case (ptr_op)
			PTR_POST_INC: ptr_next = inc_val;
			PTR_POST_DEC: ptr_next = dec_val;
			PTR_PRE_INC:  ptr_next = inc_val;
			default:      ptr_next = ptr_cur;
		endcase
		ptr_addr = (ptr_op == PTR_PRE_INC) ? inc_val : ptr_cur; // RQ19
	end

endmodule

module carry_adder
	import opaddr_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input  wire logic [WIDTH-1:0] add_a,
	input  wire logic [WIDTH-1:0] add_b,
	input  wire logic             carry_in,
	output logic      [WIDTH:0]   sum_out
);
	import opaddr_pkg::*;

	assign sum_out = {1'b0, add_a} + {1'b0, add_b} + {{WIDTH{1'b0}}, carry_in};

endmodule

//--- core/opaddr_pkg.sv
// Package with register map, field layout and types for the operand address and flag block.
package opaddr_pkg;

	localparam logic [11:0] ACCESS_SPLIT_ADDR  = 12'h060;
	localparam logic [7:0]  INDEXED_MAX_OFFSET = 8'h5F;
	localparam logic [3:0]  ACCESS_HIGH_BANK   = 4'hF;

	// Register byte addresses on APB.
	localparam logic [11:0] REG_FLAGS_ADDR     = 12'h000;
	localparam logic [11:0] REG_BANK_ADDR      = 12'h004;
	localparam logic [11:0] REG_PTR0_ADDR      = 12'h008;
	localparam logic [11:0] REG_PTR1_ADDR      = 12'h00C;
	localparam logic [11:0] REG_PTR2_ADDR      = 12'h010;
	localparam logic [11:0] REG_CONFIG_ADDR    = 12'h014;
	localparam logic [11:0] REG_TARGET_ADDR    = 12'h018;

	// Flag bit positions.
	localparam int FLAG_CARRY    = 0;
	localparam int FLAG_NIBBLE   = 1;
	localparam int FLAG_ZERO     = 2;
	localparam int FLAG_SIGNED   = 3;
	localparam int FLAG_NEGATIVE = 4;

	localparam logic [4:0]  FLAGS_RESET        = 5'h00;
	localparam logic [3:0]  BANK_RESET         = 4'h0;
	localparam logic [11:0] PTR_RESET          = 12'h000;
	localparam logic        EXT_RESET          = 1'b0;

	// Address sources selected by the decoder.
	typedef enum logic [2:0]
	{
		SRC_INHERENT,
		SRC_LITERAL,
		SRC_DIRECT,
		SRC_FULL_ADDR,
		SRC_INDIRECT
	} addr_src_e;

	// Pointer actions of the virtual operands.
	typedef enum logic [1:0]
	{
		PTR_PLAIN,
		PTR_POST_INC,
		PTR_POST_DEC,
		PTR_PRE_INC
	} ptr_op_e;

	// ALU operation classes; every class except ALU_NONE updates flags.
	typedef enum logic [2:0]
	{
		ALU_NONE,
		ALU_ADD,
		ALU_SUB,
		ALU_LOGIC,
		ALU_ROT_LEFT_CARRY,
		ALU_ROT_RIGHT_CARRY,
		ALU_CLEAR
	} alu_op_e;

	// One instruction request from the decoder.
	typedef struct packed
	{
		logic        valid;
		addr_src_e   src;
		logic [7:0]  file_addr;
		logic [11:0] full_addr;
		logic        access_sel;
		logic        dest_sel;
		logic [1:0]  ptr_sel;
		ptr_op_e     ptr_op;
		alu_op_e     alu_op;
		logic [7:0]  opa;
		logic [7:0]  opb;
		logic [7:0]  write_val;
		logic [19:0] jump_target;
	} instr_s;

	// Resolved data memory access and result routing.
	typedef struct packed
	{
		logic        mem_valid;
		logic [11:0] mem_addr;
		logic        to_accumulator;
		logic [7:0]  result;
		logic [19:0] jump_target;
		logic        flag_write;
	} access_s;

endpackage

//--- tb/opaddr_asserts.sv
// Concurrent checks on the ports of the operand address and flag block.
`timescale 1ns/1ps
module opaddr_asserts
	import opaddr_pkg::*;
(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire opaddr_pkg::instr_s  instr,
	input wire opaddr_pkg::access_s access
);
	import opaddr_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_bank;
		instr.valid && instr.src == SRC_DIRECT && instr.access_sel
		|=> access.mem_valid && access.mem_addr[7:0] == $past(instr.file_addr);
	endproperty
	property p_forced;
		instr.valid && instr.src == SRC_DIRECT && !instr.access_sel && instr.file_addr >= 8'h60
		|=> access.mem_addr == {4'hF, $past(instr.file_addr)};
	endproperty
	property p_full;
		instr.valid && instr.src == SRC_FULL_ADDR |=> access.mem_addr == $past(instr.full_addr);
	endproperty
	property p_dest;
		instr.valid && instr.src == SRC_DIRECT |=> access.to_accumulator == !$past(instr.dest_sel);
	endproperty
	property p_jump;
		instr.valid |=> access.jump_target == $past(instr.jump_target);
	endproperty
	property p_add;
		instr.valid && instr.alu_op == ALU_ADD
		|=> access.result == $past(instr.opa) + $past(instr.opb);
	endproperty
	property p_sub;
		instr.valid && instr.alu_op == ALU_SUB
		|=> access.result == $past(instr.opa) - $past(instr.opb);
	endproperty
	property p_upper;
		psel && !penable && paddr == REG_FLAGS_ADDR ##1 psel && penable |-> prdata[31:5] == '0;
	endproperty
	a_bank: assert property (p_bank) else $error("bank address");
	a_forced: assert property (p_forced) else $error("access bank");
	a_full: assert property (p_full) else $error("full address");
	a_dest: assert property (p_dest) else $error("destination");
	a_jump: assert property (p_jump) else $error("jump target");
	a_add: assert property (p_add) else $error("add result");
	a_sub: assert property (p_sub) else $error("sub result");
	a_upper: assert property (p_upper) else $error("upper flag bits");
	c_add: cover property (instr.valid && instr.alu_op == ALU_ADD);
	c_ind: cover property (instr.valid && instr.src == SRC_INDIRECT);
	c_err: cover property (pslverr && pready);
	c_flag: cover property (access.flag_write);
endmodule
bind operand_address_flags opaddr_asserts opaddr_asserts_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr), .access(access));

//--- tb/decoder_model.sv
// Decoder model that hands one instruction request at a time to the block.
`timescale 1ns/1ps
module decoder_model
	import opaddr_pkg::*;
(
	input  wire logic          pclk,
	output opaddr_pkg::instr_s instr
);
	initial instr = '0;
	task issue(input instr_s v);
		@(posedge pclk);
		instr <= v;
		@(posedge pclk);
		instr <= '0;
	endtask
endmodule

//--- tb/operand_address_flags_tb.sv
// Self-checking bench for the operand address and flag block.
`timescale 1ns/1ps
module operand_address_flags_tb;
	import opaddr_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        err;
	instr_s      instr;
	access_s     access;
	int          num_errors = 0;
	int          n_checks = 0;
	always #2 pclk = ~pclk;
	operand_address_flags operand_address_flags_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr), .access(access));
	decoder_model decoder_model_i (.pclk(pclk), .instr(instr));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task ins(input addr_src_e s, input logic [7:0] f, input logic a, input ptr_op_e p,
		input alu_op_e o, input logic [7:0] x, input logic [7:0] y);
		instr_s v;
		v = '0;
		v.valid = 1'b1;
		v.src = s;
		v.file_addr = f;
		v.access_sel = a;
		v.dest_sel = a;
		v.ptr_op = p;
		v.alu_op = o;
		v.opa = x;
		v.opb = y;
		v.write_val = y;
		v.full_addr = 12'h5A5;
		v.jump_target = 20'hABCDE;
		decoder_model_i.issue(v);
		#1;
	endtask
	task alu(input alu_op_e o, input logic [7:0] x, input logic [7:0] y);
		ins(SRC_INHERENT, 8'h00, 1'b0, PTR_PLAIN, o, x, y);
		apb(1'b0, REG_FLAGS_ADDR, 32'h0);
	endtask
	task conclude;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#20000;
		num_errors++;
		conclude();
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, REG_FLAGS_ADDR, 32'hFF);
		apb(1'b0, REG_FLAGS_ADDR, 32'h0);
		chk(rd, 32'h1F);
		apb(1'b1, REG_BANK_ADDR, 32'h2);
		ins(SRC_DIRECT, 8'h34, 1'b1, PTR_PLAIN, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'h234);
		ins(SRC_DIRECT, 8'h34, 1'b0, PTR_PLAIN, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'h034);
		ins(SRC_DIRECT, 8'h80, 1'b0, PTR_PLAIN, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'hF80);
		ins(SRC_FULL_ADDR, 8'h00, 1'b1, PTR_PLAIN, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'h5A5);
		apb(1'b1, REG_PTR0_ADDR, 32'h0FF);
		ins(SRC_INDIRECT, 8'h00, 1'b1, PTR_POST_INC, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'h0FF);
		apb(1'b0, REG_PTR0_ADDR, 32'h0);
		chk(rd, 32'h100);
		apb(1'b0, REG_FLAGS_ADDR, 32'h0);
		chk(rd, 32'h1F);
		ins(SRC_INDIRECT, 8'h00, 1'b0, PTR_PRE_INC, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'h101);
		apb(1'b1, REG_PTR0_ADDR, 32'h000);
		ins(SRC_INDIRECT, 8'h00, 1'b1, PTR_PLAIN, ALU_NONE, 8'h00, 8'h0B);
		chk(32'(access.flag_write), 32'h1);
		apb(1'b0, REG_FLAGS_ADDR, 32'h0);
		chk(rd, 32'h0B);
		ins(SRC_INDIRECT, 8'h00, 1'b1, PTR_PLAIN, ALU_ADD, 8'h01, 8'h01);
		chk(32'(access.result), 32'h02);
		apb(1'b0, REG_FLAGS_ADDR, 32'h0);
		chk(rd, 32'h00);
		ins(SRC_INDIRECT, 8'h00, 1'b1, PTR_PLAIN, ALU_CLEAR, 8'h00, 8'h00);
		apb(1'b0, REG_FLAGS_ADDR, 32'h0);
		chk(rd, 32'h04);
		alu(ALU_ADD, 8'h7F, 8'h01);
		chk(rd, 32'h1A);
		alu(ALU_SUB, 8'h05, 8'h05);
		chk(rd, 32'h07);
		alu(ALU_SUB, 8'h00, 8'h01);
		chk(rd, 32'h10);
		alu(ALU_ADD, 8'h80, 8'h80);
		chk(rd, 32'h0D);
		apb(1'b1, REG_FLAGS_ADDR, 32'h11);
		alu(ALU_CLEAR, 8'h00, 8'h00);
		chk(rd, 32'h15);
		alu(ALU_ROT_LEFT_CARRY, 8'h80, 8'h00);
		chk(rd & 32'h3, 32'h1);
		alu(ALU_ROT_RIGHT_CARRY, 8'h10, 8'h00);
		chk(rd & 32'h3, 32'h2);
		apb(1'b1, REG_CONFIG_ADDR, 32'h1);
		apb(1'b1, REG_PTR2_ADDR, 32'h200);
		ins(SRC_DIRECT, 8'h10, 1'b0, PTR_PLAIN, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'h210);
		ins(SRC_DIRECT, 8'h60, 1'b0, PTR_PLAIN, ALU_NONE, 8'h00, 8'h00);
		chk(32'(access.mem_addr), 32'hF60);
		apb(1'b0, 12'h020, 32'h0);
		chk(32'(err), 32'h1);
		conclude();
	end
endmodule
